/* tcp_map.svh */
// Purpose: Register offsets, field positions and reset values of the port
// Assumes: 8-bit byte offsets on the register port
// Notes: Definitions only
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH
// Port 1 offsets
`define TCP_P1_BURST 8'h00
`define TCP_P1_LIM1 8'hA0
`define TCP_P1_LIM2 8'hA4
`define TCP_P1_LIM3 8'hA8
`define TCP_P1_WDOG 8'hAC
`define TCP_P1_FADDR 8'hB0
`define TCP_P1_CAUSE 8'hB4
// Shared configuration
`define TCP_CONFIG 8'hB8
// Port 2 offsets
`define TCP_P2_BURST 8'hD0
`define TCP_P2_LIM1 8'hD4
`define TCP_P2_LIM2 8'hD8
`define TCP_P2_LIM3 8'hDC
`define TCP_P2_WDOG 8'hE0
`define TCP_P2_FADDR 8'hE4
`define TCP_P2_CAUSE 8'hE8
// Burst allowance fields
`define TCP_BA_MPU_LSB 0
`define TCP_BA_DSP_LSB 4
`define TCP_BA_DMA_LSB 8
`define TCP_BA_EXT_LSB 12
`define TCP_BA_MASK 16'hF777
`define TCP_BA_RST 16'h0000
// Wait limit fields
`define TCP_LIM_DSP_LSB 16
`define TCP_LIM_RST 8'h00
// Watchdog fields
`define TCP_WD_EN_BIT 8
`define TCP_WD_RST 9'h1FF
// Fault cause fields
`define TCP_FC_TOE_BIT 4
`define TCP_FC_BUS_BIT 3
`define TCP_FC_HID_LSB 1
`define TCP_FC_FLAG_BIT 0
// Configuration fields
`define TCP_CFG_PIPE_BIT 1
`define TCP_CFG_GATE_BIT 0
`define TCP_CFG_RST 2'h2
`endif

/* tcp_pkg.sv */
// Purpose: Types shared by the target port
// Assumes: Five requesters, one slave
// Notes: Constants live in tcp_map.svh
package tcp_pkg;
    // Host request
    typedef struct packed {
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } tcp_req_t;
    // Outstanding access record
    typedef struct packed {
        logic [2:0] host;
        logic rd;
        logic [31:0] addr;
    } tcp_slot_t;
    // Slave response codes
    typedef enum logic [1:0] {
        TCP_RESP_NULL = 2'h0,
        TCP_RESP_DVA = 2'h1,
        TCP_RESP_ERR = 2'h3
    } tcp_resp_t;
    // Command stage states
    typedef enum logic [1:0] {
        TCP_CMD_IDLE = 2'b01,
        TCP_CMD_ISSUE = 2'b10
    } tcp_cmd_st_t;
endpackage

/* tcp_slave_model.sv */
// Purpose: Slave peripheral model on the far side of the target port
// Assumes: One access in flight at a time
// Notes: Mode 0 answers data valid, 1 answers error, 2 stays silent
`timescale 1ns/1ns

module tcp_slave_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Command from the port
    input wire logic cmd_valid_in,
    input wire logic [31:0] addr_in,
    input wire logic [1:0] mode_in,
    // Answers to the port
    output logic accept_out,
    output logic [1:0] resp_out,
    output logic [31:0] rdata_out
);
    logic [1:0] cnt_q;
    logic [31:0] addr_q;

    // Late accept so the port must hold its command
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            accept_out <= 1'b0;
            cnt_q <= 2'h0;
            addr_q <= 32'h0;
        end
        else
        begin
            accept_out <= cmd_valid_in && !accept_out;
            if (cmd_valid_in && accept_out)
            begin
                cnt_q <= 2'h2;
                addr_q <= addr_in;
            end
            else if (cnt_q != 2'h0)
                cnt_q <= cnt_q - 2'h1;
        end
    end

    // answer inside count
    // Data toggles outside answers so stale data never looks valid
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            resp_out <= tcp_pkg::TCP_RESP_NULL;
            rdata_out <= 32'h0;
        end
        else
        begin
            resp_out <= tcp_pkg::TCP_RESP_NULL;
            rdata_out <= ~rdata_out;
            if (cnt_q == 2'h1 && mode_in != 2'h2)
            begin
                resp_out <= (mode_in == 2'h1) ? tcp_pkg::TCP_RESP_ERR
                                              : tcp_pkg::TCP_RESP_DVA;
                rdata_out <= ~addr_q;
            end
        end
    end
endmodule

/* tcp_target_port.sv */
// Purpose: Target port arbiter with response watchdog and fault record
// Assumes: Hosts 0 MPU, 1 DSP, 2 DMA, 3 external initiator, 4 LCD
// Notes: Hosts hold a request until its accept pulse is seen
//
// Function
// - A winning host keeps the port for its programmed burst of accesses.
// - Processor allowance in bits 2:0, signal processor in 6:4, reset 0.
// - DMA allowance in bits 10:8, external initiator in 15:12, reset 0.
// - Processor and signal processor get one to eight accesses.
// - External initiator gets one to sixteen accesses, DMA one to eight.
// - First wait limit bits 7:0 promote DMA after one cycle more than that many.
// - Second wait limit bits 23:16 promote signal processor requests.
// - Second wait limit bits 7:0 promote display controller requests.
// - Third wait limit bits 7:0 promote external initiator requests.
// - Watchdog bit 8 enables the response watchdog, reset enabled.
// - Watchdog bits 7:0 hold the response countdown, reset 0xFF.
// - Countdown expiry before a slave response aborts the host's access.
// - Abort captures the full access address into the fault address.
// - Fault cause bit 4 marks a watchdog abort.
// - Fault cause bit 3 marks a slave error response abort.
// - Fault cause bits 2:1 name the aborted host; display controller aborts report as DMA.
// - Fault cause bit 0 is one while an abort is recorded.
// - Overlapped reads issue the next read once the previous is accepted.
// - Configuration bit 0 enables idle clock gating.
`timescale 1ns/1ns
`include "tcp_map.svh"

module tcp_target_port #(
    parameter int PORT_NUM = 1
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // Register port
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    // Host side
    input wire logic [4:0] REQ_VALID_IN,
    input tcp_pkg::tcp_req_t [4:0] REQ_IN,
    output logic [4:0] REQ_ACCEPT_OUT,
    output logic [4:0] RESP_DONE_OUT,
    output logic [4:0] RESP_ABORT_OUT,
    output logic [31:0] HOST_RDATA_OUT,
    // Slave side
    output logic SLV_CMD_VALID_OUT,
    output logic SLV_CMD_RD_OUT,
    output logic [31:0] SLV_ADDR_OUT,
    output logic [31:0] SLV_WDATA_OUT,
    input wire logic SLV_CMD_ACCEPT_IN,
    input wire logic [1:0] SLV_RESP_IN,
    input wire logic [31:0] SLV_RDATA_IN,
    // Status
    output logic ABORT_EVT_OUT,
    output logic IDLE_GATE_OUT
);

    // ************************************************************
    // Register decode
    // ************************************************************

    localparam logic [7:0] OFF_BURST = (PORT_NUM == 1) ?
        `TCP_P1_BURST : `TCP_P2_BURST;
    localparam logic [7:0] OFF_LIM1 = (PORT_NUM == 1) ?
        `TCP_P1_LIM1 : `TCP_P2_LIM1;
    localparam logic [7:0] OFF_LIM2 = (PORT_NUM == 1) ?
        `TCP_P1_LIM2 : `TCP_P2_LIM2;
    localparam logic [7:0] OFF_LIM3 = (PORT_NUM == 1) ?
        `TCP_P1_LIM3 : `TCP_P2_LIM3;
    localparam logic [7:0] OFF_WDOG = (PORT_NUM == 1) ?
        `TCP_P1_WDOG : `TCP_P2_WDOG;
    localparam logic [7:0] OFF_FADDR = (PORT_NUM == 1) ?
        `TCP_P1_FADDR : `TCP_P2_FADDR;
    localparam logic [7:0] OFF_CAUSE = (PORT_NUM == 1) ?
        `TCP_P1_CAUSE : `TCP_P2_CAUSE;

    logic [15:0] burst_q;
    logic [7:0] lim_dma_q;
    logic [7:0] lim_dsp_q;
    logic [7:0] lim_lcd_q;
    logic [7:0] lim_ext_q;
    logic [8:0] wd_q;
    logic [1:0] cfg_q;
    logic [31:0] faddr_q;
    logic toe_q;
    logic bus_q;
    logic [1:0] hid_q;
    logic flag_q;
    logic [31:0] rd_mux;
    logic cause_rd;

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Allowance field of a host; value n grants n+1 accesses
    function automatic logic [3:0] alw(input logic [2:0] h,
                                       input logic [15:0] b);
        logic [3:0] r;
        r = 4'h0;
        case (h)
            3'h0: r = {1'b0, b[`TCP_BA_MPU_LSB +: 3]};
            3'h1: r = {1'b0, b[`TCP_BA_DSP_LSB +: 3]};
            3'h2: r = b[`TCP_BA_DMA_LSB +: 4];
            3'h3: r = b[`TCP_BA_EXT_LSB +: 4];
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // Host code for the fault record; display traffic reports as DMA
    function automatic logic [1:0] hcode(input logic [2:0] h);
        return (h == 3'h4) ? 2'h2 : h[1:0];
    endfunction

    // Round robin pick, nearest after start wins
    function automatic logic [2:0] rr_pick(input logic [4:0] c,
                                           input logic [2:0] start);
        logic [2:0] r;
        int j;
        r = start;
        j = 0;
        for (int i = 4; i >= 0; i--)
        begin
            j = (int'(start) + 1 + i) % 5;
            if (c[j])
                r = 3'(j);
        end
        return r;
    endfunction

    // ************************************************************
    // Arbitration
    // ************************************************************

    tcp_pkg::tcp_cmd_st_t st_q;
    logic [2:0] owner_q;
    logic own_v_q;
    logic [3:0] burst_left_q;
    logic [2:0] cmd_host_q;
    logic [4:0] acc_q;
    logic [4:0] high_q;
    logic [7:0] cnt_q [5];
    logic [7:0] lim [5];
    logic [1:0] out_cnt_q;
    tcp_pkg::tcp_slot_t slot_q [2];
    logic [4:0] elig;
    logic [4:0] cands;
    logic cont;
    logic [2:0] pick;
    logic can_issue;
    logic load;

    // Limits per host; the processor core is never promoted
    assign lim[0] = 8'hFF;
    assign lim[1] = lim_dsp_q;
    assign lim[2] = lim_dma_q;
    assign lim[3] = lim_ext_q;
    assign lim[4] = lim_lcd_q;

    // Mask the cycle of the accept pulse so one request is taken once
    assign elig = REQ_VALID_IN & ~acc_q;
    assign cands = ((elig & high_q) != 5'h0) ? (elig & high_q) : elig;
    assign cont = own_v_q && elig[owner_q] && (burst_left_q != 4'h0);
    assign pick = cont ? owner_q : rr_pick(cands, owner_q);
    assign can_issue = (out_cnt_q == 2'h0) ||
        (cfg_q[`TCP_CFG_PIPE_BIT] && (out_cnt_q == 2'h1) &&
         slot_q[0].rd && REQ_IN[pick].rd);
    assign load = (st_q == tcp_pkg::TCP_CMD_IDLE) && (elig != 5'h0) &&
        can_issue;

    // Burst ownership tracking
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            owner_q <= 3'h0;
            own_v_q <= 1'b0;
            burst_left_q <= 4'h0;
        end
        else if (load)
        begin
            owner_q <= pick;
            own_v_q <= 1'b1;
            burst_left_q <= cont ? burst_left_q - 4'h1 : alw(pick, burst_q);
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            high_q <= 5'h0;
            for (int i = 0; i < 5; i++)
                cnt_q[i] <= 8'h0;
        end
        else
        begin
            for (int i = 1; i < 5; i++)
            begin
                if (load && (pick == 3'(i)))
                begin
                    cnt_q[i] <= 8'h0;
                    high_q[i] <= 1'b0;
                end
                else if (elig[i] && !high_q[i])
                begin
                    if (cnt_q[i] == lim[i])
                        high_q[i] <= 1'b1;
                    else
                        cnt_q[i] <= cnt_q[i] + 8'h1;
                end
                else if (!REQ_VALID_IN[i])
                begin
                    cnt_q[i] <= 8'h0;
                    high_q[i] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Command stage
    // ************************************************************

    logic push;
    assign push = (st_q == tcp_pkg::TCP_CMD_ISSUE) && SLV_CMD_ACCEPT_IN;

    // Command held toward the slave until it accepts
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            st_q <= tcp_pkg::TCP_CMD_IDLE;
            cmd_host_q <= 3'h0;
            SLV_CMD_VALID_OUT <= 1'b0;
            SLV_CMD_RD_OUT <= 1'b0;
            SLV_ADDR_OUT <= 32'h0;
            SLV_WDATA_OUT <= 32'h0;
        end
        else
        begin
            case (st_q)
                tcp_pkg::TCP_CMD_IDLE:
                    if (load)
                    begin
                        st_q <= tcp_pkg::TCP_CMD_ISSUE;
                        cmd_host_q <= pick;
                        SLV_CMD_VALID_OUT <= 1'b1;
                        SLV_CMD_RD_OUT <= REQ_IN[pick].rd;
                        SLV_ADDR_OUT <= REQ_IN[pick].addr;
                        SLV_WDATA_OUT <= REQ_IN[pick].wdata;
                    end
                tcp_pkg::TCP_CMD_ISSUE:
                    if (SLV_CMD_ACCEPT_IN)
                    begin
                        st_q <= tcp_pkg::TCP_CMD_IDLE;
                        SLV_CMD_VALID_OUT <= 1'b0;
                    end
                default:
                    st_q <= tcp_pkg::TCP_CMD_IDLE;
            endcase
        end
    end

    // Accept pulse back to the host
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            acc_q <= 5'h0;
        else
            acc_q <= push ? (5'h1 << cmd_host_q) : 5'h0;
    end
    assign REQ_ACCEPT_OUT = acc_q;

    // ************************************************************
    // Response tracking and watchdog
    // ************************************************************

    logic [7:0] wd_cnt_q;
    logic resp_dva;
    logic resp_err;
    logic wd_exp;
    logic pop;
    logic [1:0] widx;

    assign resp_dva = (out_cnt_q != 2'h0) &&
        (SLV_RESP_IN == tcp_pkg::TCP_RESP_DVA);
    assign resp_err = (out_cnt_q != 2'h0) &&
        (SLV_RESP_IN == tcp_pkg::TCP_RESP_ERR);
    assign wd_exp = (out_cnt_q != 2'h0) &&
        (SLV_RESP_IN == tcp_pkg::TCP_RESP_NULL) &&
        wd_q[`TCP_WD_EN_BIT] && (wd_cnt_q == 8'h0);
    assign pop = resp_dva || resp_err || wd_exp;
    assign widx = out_cnt_q - {1'b0, pop};

    // Two-deep record of accepted accesses, oldest in slot 0
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            out_cnt_q <= 2'h0;
            slot_q[0] <= '0;
            slot_q[1] <= '0;
        end
        else
        begin
            out_cnt_q <= out_cnt_q + {1'b0, push} - {1'b0, pop};
            if (pop)
                slot_q[0] <= slot_q[1];
            if (push)
                slot_q[widx[0]] <= '{host: cmd_host_q, rd: SLV_CMD_RD_OUT,
                                     addr: SLV_ADDR_OUT};
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            wd_cnt_q <= 8'hFF;
        else if (pop || (out_cnt_q == 2'h0))
            wd_cnt_q <= wd_q[7:0];
        else if (wd_cnt_q != 8'h0)
            wd_cnt_q <= wd_cnt_q - 8'h1;
    end

    // Completion and abort pulses to hosts
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            RESP_DONE_OUT <= 5'h0;
            RESP_ABORT_OUT <= 5'h0;
            HOST_RDATA_OUT <= 32'h0;
        end
        else
        begin
            RESP_DONE_OUT <= resp_dva ? (5'h1 << slot_q[0].host) : 5'h0;
            RESP_ABORT_OUT <= (resp_err || wd_exp) ?
                (5'h1 << slot_q[0].host) : 5'h0;
            if (resp_dva)
                HOST_RDATA_OUT <= SLV_RDATA_IN;
        end
    end

    // ************************************************************
    // Fault record
    // ************************************************************

    assign cause_rd = REG_RD_IN && (REG_ADDR_IN == OFF_CAUSE);

    // New abort wins over a clearing read in the same cycle
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            faddr_q <= 32'h0;
            toe_q <= 1'b0;
            bus_q <= 1'b0;
            hid_q <= 2'h0;
            flag_q <= 1'b0;
        end
        else if (resp_err || wd_exp)
        begin
            faddr_q <= slot_q[0].addr;
            toe_q <= wd_exp;
            bus_q <= resp_err;
            hid_q <= hcode(slot_q[0].host);
            flag_q <= 1'b1;
        end
        else if (cause_rd)
        begin
            toe_q <= 1'b0;
            bus_q <= 1'b0;
            hid_q <= 2'h0;
            flag_q <= 1'b0;
        end
    end

    // ************************************************************
    // Register writes and reads
    // ************************************************************

    // Software-written control
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            burst_q <= `TCP_BA_RST;
            lim_dma_q <= `TCP_LIM_RST;
            lim_dsp_q <= `TCP_LIM_RST;
            lim_lcd_q <= `TCP_LIM_RST;
            lim_ext_q <= `TCP_LIM_RST;
            wd_q <= `TCP_WD_RST;
            cfg_q <= `TCP_CFG_RST;
        end
        else if (REG_WR_IN)
        begin
            case (REG_ADDR_IN)
                OFF_BURST: burst_q <= REG_WDATA_IN[15:0] & `TCP_BA_MASK;
                OFF_LIM1: lim_dma_q <= REG_WDATA_IN[7:0];
                OFF_LIM2:
                begin
                    lim_dsp_q <= REG_WDATA_IN[`TCP_LIM_DSP_LSB +: 8];
                    lim_lcd_q <= REG_WDATA_IN[7:0];
                end
                OFF_LIM3: lim_ext_q <= REG_WDATA_IN[7:0];
                OFF_WDOG: wd_q <= REG_WDATA_IN[8:0];
                `TCP_CONFIG: cfg_q <= REG_WDATA_IN[1:0];
                default: cfg_q <= cfg_q;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rd_mux = 32'h0;
        case (REG_ADDR_IN)
            OFF_BURST: rd_mux = {16'h0, burst_q};
            OFF_LIM1: rd_mux = {24'h0, lim_dma_q};
            OFF_LIM2: rd_mux = {8'h0, lim_dsp_q, 8'h0, lim_lcd_q};
            OFF_LIM3: rd_mux = {24'h0, lim_ext_q};
            OFF_WDOG: rd_mux = {23'h0, wd_q};
            OFF_FADDR: rd_mux = faddr_q;
            OFF_CAUSE: rd_mux = {27'h0, toe_q, bus_q, hid_q, flag_q};
            `TCP_CONFIG: rd_mux = {30'h0, cfg_q};
            default: rd_mux = 32'h0;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            REG_RDATA_OUT <= 32'h0;
        else
            REG_RDATA_OUT <= REG_RD_IN ? rd_mux : 32'h0;
    end

    // Abort event level and idle gating request
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            ABORT_EVT_OUT <= 1'b0;
            IDLE_GATE_OUT <= 1'b0;
        end
        else
        begin
            ABORT_EVT_OUT <= flag_q;
            IDLE_GATE_OUT <= cfg_q[`TCP_CFG_GATE_BIT] && (elig == 5'h0) &&
                (out_cnt_q == 2'h0) && (st_q == tcp_pkg::TCP_CMD_IDLE);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    sequence wd_expiry_s;
        (out_cnt_q != 2'h0) && wd_q[8] && (wd_cnt_q == 8'h0) &&
            (SLV_RESP_IN == tcp_pkg::TCP_RESP_NULL);
    endsequence

    sequence err_resp_s;
        (out_cnt_q != 2'h0) && (SLV_RESP_IN == tcp_pkg::TCP_RESP_ERR);
    endsequence

    burst_cap_a: assert property (
        own_v_q |-> burst_left_q <= alw(owner_q, burst_q))
        else $error("burst count above allowance");
    wd_abort_a: assert property (
        wd_expiry_s |=> flag_q && toe_q && !bus_q &&
            (RESP_ABORT_OUT == (5'h1 << $past(slot_q[0].host))))
        else $error("watchdog expiry did not abort");
    err_abort_a: assert property (
        err_resp_s |=> flag_q && bus_q && !toe_q)
        else $error("slave error did not abort");
    fault_addr_a: assert property (
        (wd_expiry_s or err_resp_s) |=> faddr_q == $past(slot_q[0].addr))
        else $error("fault address not captured");
    read_clear_a: assert property (
        (cause_rd && !resp_err && !wd_exp) |=> !flag_q ##1 !ABORT_EVT_OUT)
        else $error("fault cause not cleared by read");
    promote_a: assert property (
        (elig[2] && !high_q[2] && (cnt_q[2] == lim_dma_q) &&
            !(load && pick == 3'h2)) |=> high_q[2])
        else $error("DMA request not promoted");
    no_overlap_a: assert property (
        (!cfg_q[1] && (out_cnt_q == 2'h1) && !pop) |-> !load)
        else $error("command issued while overlap disabled");
    gate_idle_a: assert property (
        IDLE_GATE_OUT |-> $past(cfg_q[0]) && ($past(out_cnt_q) == 2'h0))
        else $error("gating requested while busy");
    wd_count_a: assert property (
        (out_cnt_q != 2'h0 && !pop && wd_cnt_q != 8'h0) |=>
            wd_cnt_q == $past(wd_cnt_q) - 8'h1)
        else $error("watchdog not counting down");

endmodule

/* tcp_target_port_tb.sv */
// Purpose: Register and host access tests of the target port
// Assumes: Port 1 offsets, slave model on the command side
// Notes: Silent slave waits out the full reset countdown
`timescale 1ns/1ns
`include "tcp_map.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    num_errors++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end end

module tcp_target_port_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] ra = 8'h00;
    logic [31:0] rw = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdat;
    logic [4:0] rv = 5'h00;
    tcp_pkg::tcp_req_t [4:0] rq = '0;
    logic [4:0] acc;
    logic [4:0] done;
    logic [4:0] abt;
    logic [31:0] hrd;
    logic sv;
    logic [31:0] sa;
    logic sacc;
    logic [1:0] sresp;
    logic [31:0] srdat;
    logic [1:0] mode = 2'h0;
    logic evt;
    logic gate;
    logic ab;
    int num_errors = 0;
    int num_checks = 0;
    localparam logic [7:0] OFS [9] = '{`TCP_P1_BURST, `TCP_P1_LIM1,
        `TCP_P1_LIM2, `TCP_P1_LIM3, `TCP_P1_WDOG, `TCP_P1_FADDR,
        `TCP_P1_CAUSE, `TCP_CONFIG, 8'h44};
    localparam logic [31:0] RSTV [9] = '{32'h0, 32'h0, 32'h0, 32'h0,
        32'h1FF, 32'h0, 32'h0, 32'h2, 32'h0};
    localparam logic [31:0] LIMV [3] = '{32'hFF, 32'hFF00FF, 32'hFF};

    initial forever #2 clk = ~clk;

    tcp_target_port #(.PORT_NUM(1)) tcp_target_port_i (.CLK_IN(clk),
        .NRST_IN(rst_n), .REG_ADDR_IN(ra), .REG_WDATA_IN(rw),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat),
        .REQ_VALID_IN(rv), .REQ_IN(rq), .REQ_ACCEPT_OUT(acc),
        .RESP_DONE_OUT(done), .RESP_ABORT_OUT(abt), .HOST_RDATA_OUT(hrd),
        .SLV_CMD_VALID_OUT(sv), .SLV_CMD_RD_OUT(), .SLV_ADDR_OUT(sa),
        .SLV_WDATA_OUT(), .SLV_CMD_ACCEPT_IN(sacc), .SLV_RESP_IN(sresp),
        .SLV_RDATA_IN(srdat), .ABORT_EVT_OUT(evt), .IDLE_GATE_OUT(gate));

    tcp_slave_model tcp_slave_model_i (.clk_in(clk), .rst_n_in(rst_n),
        .cmd_valid_in(sv), .addr_in(sa), .mode_in(mode),
        .accept_out(sacc), .resp_out(sresp), .rdata_out(srdat));

    task automatic wrap_up();
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a;
        rw <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK($sformatf("reg %h", a), ex, rdat)
    endtask

    // Request held until its accept pulse, then bounded wait for the end
    task automatic access(input int h, input logic [31:0] a,
                          input logic [1:0] m);
        int n;
        n = 0;
        @(posedge clk);
        mode <= m;
        rq[h] <= '{1'b1, a, ~a};
        rv[h] <= 1'b1;
        do @(posedge clk); while (!acc[h] && ++n < 300);
        rv[h] <= 1'b0;
        do @(posedge clk); while (!(done[h] | abt[h]) && ++n < 600);
        ab = abt[h];
        // Neither pulse seen: the bounded wait ran out
        if (!(done[h] | abt[h]))
        begin
            $display("[FAIL] host %0d access expected end seen none", h);
            num_errors++;
            wrap_up();
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            reg_rd(OFS[i], RSTV[i]);
        // Reserved bits and a read-only place ignore writes
        reg_wr(`TCP_P1_BURST, 32'hFFFFFFFF);
        reg_rd(`TCP_P1_BURST, 32'hF777);
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(OFS[i + 1], 32'hFFFFFFFF);
            reg_rd(OFS[i + 1], LIMV[i]);
        end
        reg_wr(`TCP_P1_FADDR, 32'hFFFFFFFF);
        reg_rd(`TCP_P1_FADDR, 32'h0);
        // Error answer from the slave, once for every host code
        for (int h = 0; h < 4; h++)
        begin
            access(h, 32'h40000010 + h, 2'h1);
            `CHK("abort", 1'b1, ab)
            reg_rd(`TCP_P1_FADDR, 32'h40000010 + h);
            `CHK("event", 1'b1, evt)
            reg_rd(`TCP_P1_CAUSE, 32'h9 | (h << 1));
            reg_rd(`TCP_P1_CAUSE, 32'h0);
        end
        // Silent slave runs the watchdog out
        access(3, 32'h80000ABC, 2'h2);
        `CHK("abort", 1'b1, ab)
        reg_rd(`TCP_P1_FADDR, 32'h80000ABC);
        reg_rd(`TCP_P1_CAUSE, 32'h17);
        // Answered read returns the slave data
        access(1, 32'h00000100, 2'h0);
        `CHK("abort", 1'b0, ab)
        `CHK("rdata", ~32'h00000100, hrd)
        // DMA queues behind a read, is promoted, then overlaps it
        reg_wr(`TCP_P1_LIM1, 32'h0);
        fork
            access(1, 32'h00000104, 2'h0);
            begin
                @(posedge clk);
                access(2, 32'h00000204, 2'h0);
            end
        join
        `CHK("rdata", ~32'h00000204, hrd)
        // Overlap off, idle gating on, one access in between
        reg_wr(`TCP_CONFIG, 32'h1);
        access(0, 32'h00000300, 2'h0);
        `CHK("abort", 1'b0, ab)
        repeat (3) @(posedge clk);
        `CHK("gate", 1'b1, gate)
        reg_rd(`TCP_CONFIG, 32'h1);
        wrap_up();
    end
endmodule
